// ===== pkg/ssst_map.svh
// Register offsets, field positions, reset values and timing figures of the
// sync and strobe timing block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef SSST_MAP_SVH
`define SSST_MAP_SVH

// ==========================================================================
// Register offsets (serial port register address space)
`define SSST_A_POWER  8'h0c
`define SSST_A_TRIST  8'h12
`define SSST_A_POL    8'h40
`define SSST_A_TRIG   8'h41
`define SSST_A_FSDLY  8'h54
`define SSST_A_RSDLY  8'h55
`define SSST_A_SLEN   8'h56
`define SSST_A_SHA    8'h5f
`define SSST_A_SHB    8'h60
`define SSST_A_PVDLY  8'h64
`define SSST_A_VCWH   8'h68
`define SSST_A_VCWL   8'h69
`define SSST_A_WRDH   8'h6a
`define SSST_A_WRDL   8'h6b
`define SSST_A_CINTH  8'h6c
`define SSST_A_CINTL  8'h6d
`define SSST_A_STRB   8'h6e
`define SSST_A_STAT   8'h70

// ==========================================================================
// Field positions
`define SSST_B_RES    1
`define SSST_B_TSCTL  0
`define SSST_B_TRIG   0
`define SSST_B_SFM    1
`define SSST_B_STREN  5
`define SSST_B_POLFS  0
`define SSST_B_POLRS  1
`define SSST_B_POLDV  2

// ==========================================================================
// Reset values
`define SSST_R_ZERO   8'h00
`define SSST_R_TRIST  8'h01
`define SSST_R_SH     8'h0a
`define SSST_R_VCW    16'h050a
`define SSST_R_WRD    16'h03ff
`define SSST_R_CINT   16'h0402

// ==========================================================================
// Timing figures, in master clock periods or rows, and the serial slave address
`define SSST_ROW_OVH  16'h0013
`define SSST_FRM_OVH  16'h0002
`define SSST_RD_OFS   16'h0001
`define SSST_STRB_LD  16'h0002
`define SSST_SLV_ADDR 7'h33

`endif

// ===== pkg/ssst_pkg.sv
// Types shared by the sync and strobe timing block.
// Assumes the map header is compiled alongside.
package ssst_pkg;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } ssst_regreq_t;

  typedef struct packed {
    logic fs;
    logic rs;
    logic dv;
    logic strb;
  } ssst_sync_t;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_REG, I2C_WDAT, I2C_ACK, I2C_RDAT, I2C_DONE
  } ssst_i2c_st_t;

  typedef enum logic [1:0] {PLS_IDLE, PLS_WAIT, PLS_HIGH} ssst_pls_st_t;

endpackage : ssst_pkg

// ===== src/ssst_pulse.sv
// Delayed pulse shaper: one trigger gives one pulse after a set delay.
// Assumes triggers are spaced wider than delay plus width.
`timescale 1ns/1ns
`default_nettype none
module ssst_pulse
  import ssst_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       trig,
  input  wire logic [8:0] delay,
  input  wire logic [3:0] len,
  output logic            pulse
);
  ssst_pls_st_t st_r;
  ssst_pls_st_t st_nxt;
  logic [8:0]   cnt_r;
  logic [8:0]   cnt_nxt;

  // A new trigger restarts the shaper, so a late pulse never swallows one
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    if (trig) begin
      st_nxt  = (delay == 9'h000) ? PLS_HIGH : PLS_WAIT;
      cnt_nxt = (delay == 9'h000) ? {5'h00, len} : delay - 9'h001;
    end else begin
      case (st_r)
        PLS_WAIT: begin
          st_nxt  = (cnt_r == 9'h000) ? PLS_HIGH : PLS_WAIT;
          cnt_nxt = (cnt_r == 9'h000) ? {5'h00, len} : cnt_r - 9'h001;
        end
        PLS_HIGH: begin
          st_nxt  = (cnt_r == 9'h000) ? PLS_IDLE : PLS_HIGH;
          cnt_nxt = cnt_r - 9'h001;
        end
        default: st_nxt = PLS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r  <= PLS_IDLE;
      cnt_r <= 9'h000;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign pulse = (st_r == PLS_HIGH);
endmodule : ssst_pulse
`default_nettype wire

// ===== src/ssst_i2c_slave.sv
// Serial register slave: one register byte per start/stop transaction.
// Assumes serial clock at most one twenty-fourth of mclk, pins synchronous.
`timescale 1ns/1ns
`default_nettype none
`include "ssst_map.svh"
module ssst_i2c_slave
  import ssst_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] rdata,
  output logic            sda_oe_n,
  output ssst_regreq_t    req
);
  ssst_i2c_st_t st_r, st_nxt, ret_r, ret_nxt;
  ssst_regreq_t req_r, req_nxt;
  logic [7:0]   sh_r, sh_nxt;
  logic [3:0]   bit_r, bit_nxt;
  logic         drvn_r, drvn_nxt;
  logic         scl_q_r;
  logic         sda_q_r;
  logic         start, stop, rise, fall;

  // Slow serial clock lets plain edge detection on mclk see every edge
  assign start = scl_i & scl_q_r & sda_q_r & ~sda_i;
  assign stop  = scl_i & scl_q_r & ~sda_q_r & sda_i;
  assign rise  = scl_i & ~scl_q_r;
  assign fall  = ~scl_i & scl_q_r;

  always_comb begin
    st_nxt   = st_r;
    ret_nxt  = ret_r;
    sh_nxt   = sh_r;
    bit_nxt  = bit_r;
    drvn_nxt = drvn_r;
    req_nxt  = req_r;
    req_nxt.wr = 1'b0;
    if (start) begin
      st_nxt   = I2C_ADDR;
      bit_nxt  = 4'h0;
      drvn_nxt = 1'b1;
    end else if (stop) begin
      st_nxt   = I2C_IDLE;
      drvn_nxt = 1'b1;
    end else begin
      case (st_r)
        I2C_ADDR, I2C_REG, I2C_WDAT: begin
          if (rise) begin
            sh_nxt  = {sh_r[6:0], sda_i};
            bit_nxt = bit_r + 4'h1;
          end else if (fall && bit_r == 4'h8) begin
            bit_nxt  = 4'h0;
            st_nxt   = I2C_ACK;
            drvn_nxt = 1'b0;
            if (st_r == I2C_ADDR) begin
              if (sh_r[7:1] != `SSST_SLV_ADDR) begin
                st_nxt   = I2C_DONE;
                drvn_nxt = 1'b1;
              end
              ret_nxt = sh_r[0] ? I2C_RDAT : I2C_REG;
            end else if (st_r == I2C_REG) begin
              req_nxt.addr = sh_r;
              ret_nxt      = I2C_WDAT;
            end else begin
              req_nxt.wr   = 1'b1;
              req_nxt.data = sh_r;
              ret_nxt      = I2C_DONE;
            end
          end
        end
        I2C_ACK: if (fall) begin
          st_nxt   = ret_r;
          drvn_nxt = 1'b1;
          if (ret_r == I2C_RDAT) begin
            sh_nxt   = rdata;
            drvn_nxt = rdata[7];
          end
        end
        I2C_RDAT: if (fall) begin
          if (bit_r == 4'h7) begin
            st_nxt   = I2C_DONE;
            drvn_nxt = 1'b1;
          end else begin
            sh_nxt   = {sh_r[6:0], 1'b0};
            drvn_nxt = sh_r[6];
            bit_nxt  = bit_r + 4'h1;
          end
        end
        default: st_nxt = st_r;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r    <= I2C_IDLE;
      ret_r   <= I2C_IDLE;
      req_r   <= '0;
      sh_r    <= 8'h00;
      bit_r   <= 4'h0;
      drvn_r  <= 1'b1;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      st_r    <= st_nxt;
      ret_r   <= ret_nxt;
      req_r   <= req_nxt;
      sh_r    <= sh_nxt;
      bit_r   <= bit_nxt;
      drvn_r  <= drvn_nxt;
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
    end
  end

  assign sda_oe_n = drvn_r;
  assign req      = req_r;
endmodule : ssst_i2c_slave
`default_nettype wire

// ===== src/ssst_top.sv
// Readout sync and strobe timing generator with its serial register port.
// Assumes synchronous pins and a 20 MHz mclk; pads resolve the enables.
`timescale 1ns/1ns
`default_nettype none
`include "ssst_map.svh"
module ssst_top
  import ssst_pkg::*;
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_n,
  output logic      frame_start,
  output logic      row_sync,
  output logic      data_valid,
  output logic      strobe,
  output logic      sync_oe_n,
  output logic      bias_res_en
);
  // ========================================================================
  // Register file
  ssst_regreq_t req;
  logic [7:0]   rdata;
  logic [7:0]   power_r, power_nxt;
  logic [7:0]   trist_r, trist_nxt;
  logic [7:0]   pol_r, pol_nxt;
  logic [7:0]   trig_r, trig_nxt;
  logic [7:0]   fsdly_r, fsdly_nxt;
  logic [7:0]   rsdly_r, rsdly_nxt;
  logic [7:0]   slen_r, slen_nxt;
  logic [7:0]   sha_r, sha_nxt;
  logic [7:0]   shb_r, shb_nxt;
  logic [7:0]   pvdly_r, pvdly_nxt;
  logic [7:0]   strb_r, strb_nxt;
  logic [15:0]  vcw_r, vcw_nxt;
  logic [15:0]  wrd_r, wrd_nxt;
  logic [15:0]  cint_r, cint_nxt;
  logic [7:0]   status;
  logic         frame_go;

  ssst_i2c_slave u_i2c (
    .mclk     (mclk),
    .resetn   (resetn),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .rdata    (rdata),
    .sda_oe_n (sda_oe_n),
    .req      (req)
  );

  always_comb begin
    power_nxt = power_r;
    trist_nxt = trist_r;
    pol_nxt   = pol_r;
    trig_nxt  = trig_r;
    fsdly_nxt = fsdly_r;
    rsdly_nxt = rsdly_r;
    slen_nxt  = slen_r;
    sha_nxt   = sha_r;
    shb_nxt   = shb_r;
    pvdly_nxt = pvdly_r;
    strb_nxt  = strb_r;
    vcw_nxt   = vcw_r;
    wrd_nxt   = wrd_r;
    cint_nxt  = cint_r;
    // Hardware clears the pending trigger first so a same-cycle write wins
    if (frame_go) begin
      trig_nxt[`SSST_B_TRIG] = 1'b0;
    end
    if (req.wr) begin
      if (req.addr == `SSST_A_POWER) begin
        power_nxt = req.data;
      end else if (req.addr == `SSST_A_TRIST) begin
        trist_nxt = req.data;
      end else if (req.addr == `SSST_A_POL) begin
        pol_nxt = req.data;
      end else if (req.addr == `SSST_A_TRIG) begin
        trig_nxt = req.data;
      end else if (req.addr == `SSST_A_FSDLY) begin
        fsdly_nxt = req.data;
      end else if (req.addr == `SSST_A_RSDLY) begin
        rsdly_nxt = req.data;
      end else if (req.addr == `SSST_A_SLEN) begin
        slen_nxt = req.data;
      end else if (req.addr == `SSST_A_SHA) begin
        sha_nxt = req.data;
      end else if (req.addr == `SSST_A_SHB) begin
        shb_nxt = req.data;
      end else if (req.addr == `SSST_A_PVDLY) begin
        pvdly_nxt = req.data;
      end else if (req.addr == `SSST_A_STRB) begin
        strb_nxt = req.data;
      end else if (req.addr == `SSST_A_VCWH) begin
        vcw_nxt[15:8] = req.data;
      end else if (req.addr == `SSST_A_VCWL) begin
        vcw_nxt[7:0] = req.data;
      end else if (req.addr == `SSST_A_WRDH) begin
        wrd_nxt[15:8] = req.data;
      end else if (req.addr == `SSST_A_WRDL) begin
        wrd_nxt[7:0] = req.data;
      end else if (req.addr == `SSST_A_CINTH) begin
        cint_nxt[15:8] = req.data;
      end else if (req.addr == `SSST_A_CINTL) begin
        cint_nxt[7:0] = req.data;
      end
    end
  end

  // Unmapped addresses read as zero
  always_comb begin
    if (req.addr == `SSST_A_POWER) begin
      rdata = power_r;
    end else if (req.addr == `SSST_A_TRIST) begin
      rdata = trist_r;
    end else if (req.addr == `SSST_A_POL) begin
      rdata = pol_r;
    end else if (req.addr == `SSST_A_TRIG) begin
      rdata = trig_r;
    end else if (req.addr == `SSST_A_FSDLY) begin
      rdata = fsdly_r;
    end else if (req.addr == `SSST_A_RSDLY) begin
      rdata = rsdly_r;
    end else if (req.addr == `SSST_A_SLEN) begin
      rdata = slen_r;
    end else if (req.addr == `SSST_A_SHA) begin
      rdata = sha_r;
    end else if (req.addr == `SSST_A_SHB) begin
      rdata = shb_r;
    end else if (req.addr == `SSST_A_PVDLY) begin
      rdata = pvdly_r;
    end else if (req.addr == `SSST_A_STRB) begin
      rdata = strb_r;
    end else if (req.addr == `SSST_A_VCWH) begin
      rdata = vcw_r[15:8];
    end else if (req.addr == `SSST_A_VCWL) begin
      rdata = vcw_r[7:0];
    end else if (req.addr == `SSST_A_WRDH) begin
      rdata = wrd_r[15:8];
    end else if (req.addr == `SSST_A_WRDL) begin
      rdata = wrd_r[7:0];
    end else if (req.addr == `SSST_A_CINTH) begin
      rdata = cint_r[15:8];
    end else if (req.addr == `SSST_A_CINTL) begin
      rdata = cint_r[7:0];
    end else if (req.addr == `SSST_A_STAT) begin
      rdata = status;
    end else begin
      rdata = 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      power_r <= `SSST_R_ZERO;
      trist_r <= `SSST_R_TRIST;
      pol_r   <= `SSST_R_ZERO;
      trig_r  <= `SSST_R_ZERO;
      fsdly_r <= `SSST_R_ZERO;
      rsdly_r <= `SSST_R_ZERO;
      slen_r  <= `SSST_R_ZERO;
      sha_r   <= `SSST_R_SH;
      shb_r   <= `SSST_R_SH;
      pvdly_r <= `SSST_R_ZERO;
      strb_r  <= `SSST_R_ZERO;
      vcw_r   <= `SSST_R_VCW;
      wrd_r   <= `SSST_R_WRD;
      cint_r  <= `SSST_R_CINT;
    end else begin
      power_r <= power_nxt;
      trist_r <= trist_nxt;
      pol_r   <= pol_nxt;
      trig_r  <= trig_nxt;
      fsdly_r <= fsdly_nxt;
      rsdly_r <= rsdly_nxt;
      slen_r  <= slen_nxt;
      sha_r   <= sha_nxt;
      shb_r   <= shb_nxt;
      pvdly_r <= pvdly_nxt;
      strb_r  <= strb_nxt;
      vcw_r   <= vcw_nxt;
      wrd_r   <= wrd_nxt;
      cint_r  <= cint_nxt;
    end
  end

  // ========================================================================
  // Frame and row counters
  logic [15:0] col_r, col_nxt;
  logic [15:0] row_r, row_nxt;
  logic        act_r, act_nxt;
  logic [15:0] row_per;
  logic [15:0] frm_rows;
  logic [15:0] rd_first;
  logic [15:0] strb_row;
  logic        cont;
  logic        readout;
  logic        row_start;
  logic        pix;
  logic        strb_on;

  // Row length changes with the sample-hold widths; no guard mid-frame
  assign row_per  = vcw_r + {8'h00, sha_r} + {8'h00, shb_r} + `SSST_ROW_OVH;
  assign frm_rows = wrd_r + cint_r + `SSST_FRM_OVH;
  assign rd_first = cint_r + `SSST_RD_OFS;
  assign cont     = ~trig_r[`SSST_B_SFM];
  assign frame_go = ~act_r & (cont | trig_r[`SSST_B_TRIG]);
  assign readout  = act_r & (row_r >= rd_first) & (row_r <= rd_first + wrd_r);
  assign row_start = readout & (col_r == 16'h0000);
  assign pix      = readout & (col_r <= vcw_r);
  // Integration rows come first, so a zero start keeps the default place
  assign strb_row = (strb_r == 8'h00) ? rd_first - `SSST_STRB_LD
                                      : {8'h00, strb_r};
  assign strb_on  = act_r & trig_r[`SSST_B_SFM] & trig_r[`SSST_B_STREN]
                    & (row_r == strb_row);
  assign status   = {5'h00, trig_r[`SSST_B_TRIG], act_r, strb_on};

  always_comb begin
    col_nxt = col_r;
    row_nxt = row_r;
    act_nxt = act_r;
    if (frame_go) begin
      act_nxt = 1'b1;
      col_nxt = 16'h0000;
      row_nxt = 16'h0000;
    end else if (act_r) begin
      if (col_r >= row_per - 16'h0001) begin
        col_nxt = 16'h0000;
        if (row_r >= frm_rows - 16'h0001) begin
          row_nxt = 16'h0000;
          act_nxt = cont;
        end else begin
          row_nxt = row_r + 16'h0001;
        end
      end else begin
        col_nxt = col_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      col_r <= 16'h0000;
      row_r <= 16'h0000;
      act_r <= 1'b0;
    end else begin
      col_r <= col_nxt;
      row_r <= row_nxt;
      act_r <= act_nxt;
    end
  end

  // ========================================================================
  // Frame-start and row sync shapers
  logic [1:0] ch_trig;
  logic [8:0] ch_dly [2];
  logic [3:0] ch_len [2];
  logic [1:0] ch_pls;

  assign ch_trig[0] = row_start & (row_r == rd_first);
  assign ch_trig[1] = row_start;
  assign ch_dly[0]  = {1'b0, fsdly_r};
  assign ch_dly[1]  = {1'b0, fsdly_r} + {1'b0, rsdly_r};
  assign ch_len[0]  = slen_r[3:0];
  assign ch_len[1]  = slen_r[7:4];

  generate
    for (genvar g = 0; g < 2; g++) begin : g_ch
      ssst_pulse u_pls (
        .mclk   (mclk),
        .resetn (resetn),
        .trig   (ch_trig[g]),
        .delay  (ch_dly[g]),
        .len    (ch_len[g]),
        .pulse  (ch_pls[g])
      );
    end
  endgenerate

  // ========================================================================
  // Data-valid delay line
  // A full tap line costs 255 flops but keeps every pixel pulse distinct
  logic [254:0] dvl_r, dvl_nxt;
  logic         dv_tap;

  always_comb begin
    dvl_nxt = {dvl_r[253:0], pix};
    dv_tap  = (pvdly_r == 8'h00) ? pix : dvl_r[pvdly_r - 8'h01];
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dvl_r <= '0;
    end else begin
      dvl_r <= dvl_nxt;
    end
  end

  // ========================================================================
  // Output stage
  ssst_sync_t sync_r, sync_nxt;
  logic       oe_n_r, oe_n_nxt;
  logic       bias_r, bias_nxt;
  logic       sda_o_r;

  always_comb begin
    sync_nxt.fs   = ch_pls[0] ^ pol_r[`SSST_B_POLFS];
    sync_nxt.rs   = ch_pls[1] ^ pol_r[`SSST_B_POLRS];
    sync_nxt.dv   = dv_tap ^ pol_r[`SSST_B_POLDV];
    sync_nxt.strb = strb_on;
    oe_n_nxt      = ~trist_r[`SSST_B_TSCTL];
    bias_nxt      = power_r[`SSST_B_RES];
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_r  <= '0;
      oe_n_r  <= 1'b0;
      bias_r  <= 1'b0;
      sda_o_r <= 1'b0;
    end else begin
      sync_r  <= sync_nxt;
      oe_n_r  <= oe_n_nxt;
      bias_r  <= bias_nxt;
      sda_o_r <= 1'b0;
    end
  end

  assign frame_start = sync_r.fs;
  assign row_sync    = sync_r.rs;
  assign data_valid  = sync_r.dv;
  assign strobe      = sync_r.strb;
  assign sync_oe_n   = oe_n_r;
  assign bias_res_en = bias_r;
  assign sda_o       = sda_o_r;
endmodule : ssst_top
`default_nettype wire

// ===== tb/ssst_monitor.sv
// Port checker for the sync and strobe timing top.
// Assumes frame and row sync polarity left at reset and default strobe start.
`timescale 1ns/1ns
`default_nettype none
module ssst_monitor (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic frame_start,
  input wire logic row_sync,
  input wire logic data_valid,
  input wire logic strobe,
  input wire logic sync_oe_n,
  input wire logic bias_res_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ====================
  // Strobe length
  logic [15:0] st_cnt_r;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) st_cnt_r <= 16'h0000;
    else st_cnt_r <= strobe ? st_cnt_r + 16'h0001 : 16'h0000;
  end
  // ====================
  // Checks
  AST_ACK_PULLS_LOW:
    assert property (!sda_oe_n |-> !sda_o) else $error("data line driven high");
  AST_SDA_MOVES_SCL_LOW:
    assert property ($changed(sda_oe_n) |-> !scl_i && !$past(scl_i))
      else $error("data line moved while serial clock high");
  AST_ACK_HOLDS:
    assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8]) else $error("ack too short");
  AST_FS_WIDTH:
    assert property ($rose(frame_start) |-> ##[1:16] !frame_start)
      else $error("frame start too long");
  AST_RS_WIDTH:
    assert property ($rose(row_sync) |-> ##[1:16] !row_sync) else $error("row sync too long");
  AST_RS_AFTER_FS:
    assert property ($rose(frame_start) |-> ##[0:255] $rose(row_sync))
      else $error("row sync missing after frame start");
  AST_STRB_CLEAR_OF_FS:
    assert property ($rose(frame_start) |-> !strobe) else $error("strobe overlaps readout");
  AST_STRB_ONE_ROW:
    assert property (st_cnt_r <= 16'h0531) else $error("strobe longer than a row");
  cover property ($fell(sda_oe_n));
  cover property ($rose(strobe));
  cover property ($rose(frame_start) ##[1:300] $rose(row_sync));
endmodule : ssst_monitor
bind ssst_top ssst_monitor ssst_monitor_i (
  .mclk(mclk), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .frame_start(frame_start), .row_sync(row_sync),
  .data_valid(data_valid), .strobe(strobe), .sync_oe_n(sync_oe_n),
  .bias_res_en(bias_res_en)
);
`default_nettype wire

// ===== tb/ssst_host.sv
// Serial bus master standing in for the capture controller.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ns
`default_nettype none
`include "ssst_map.svh"
module ssst_host (
  input  wire logic mclk,
  input  wire logic sda_w,
  output logic      scl_m,
  output logic      sda_m
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // ====================
  // Bit level
  // Twelve mclk per phase: the slave cannot follow a faster clock
  task automatic put(input logic d);
    scl_m <= 1'b0;
    repeat (6) @(posedge mclk);
    sda_m <= d;
    repeat (6) @(posedge mclk);
    scl_m <= 1'b1;
    repeat (12) @(posedge mclk);
  endtask : put
  task automatic start;
    put(1'b1);
    sda_m <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask : start
  task automatic stop;
    put(1'b0);
    sda_m <= 1'b1;
    repeat (12) @(posedge mclk);
  endtask : stop
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) put(b[i]);
    put(1'b1);
    ack = !sda_w;
  endtask : put_byte
  task automatic get_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      put(1'b1);
      d[i] = sda_w;
    end
    put(1'b1);
  endtask : get_byte
  // ====================
  // One register byte per transaction
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    // Callers may return on a falling edge; pins only move after a rising one
    @(posedge mclk);
    start();
    put_byte({`SSST_SLV_ADDR, 1'b0}, k1);
    put_byte(a, k2);
    put_byte(d, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    @(posedge mclk);
    start();
    put_byte({`SSST_SLV_ADDR, 1'b0}, k1);
    put_byte(a, k2);
    start();
    put_byte({`SSST_SLV_ADDR, 1'b1}, k3);
    get_byte(d);
    stop();
    ok = k1 & k2 & k3;
  endtask : rd
endmodule : ssst_host
`default_nettype wire

// ===== tb/ssst_top_tb.sv
// Self-checking bench for the sync and strobe timing top.
// Assumes the host model and the bound checker; small counts shorten frames.
`timescale 1ns/1ns
`default_nettype none
`include "ssst_map.svh"
module ssst_top_tb;
  // Row is vcw 4 + two holds of 1 + 19; frame is wrd 2 + cint 5 + 2 rows
  localparam int ROW = 25;
  localparam int FRM = 9 * ROW;
  logic mclk;
  logic resetn;
  logic scl_m, sda_m, sda_o, sda_oe_n, fs, rs, dv, st, soe, bias;
  logic sda_w;
  logic fs_q, rs_q, dv_q, st_q;
  int   n_mismatch, comparisons, cyc, fs_t, rs_t, st_t, fs_len, rs_len, st_len;
  int   rs_min, rs_off, fs_gap, st_gap, dv_n, dv_acc, dv_off;
  assign sda_w = sda_m & (sda_oe_n | sda_o);
  ssst_top ssst_top_i (
    .mclk(mclk), .resetn(resetn), .scl_i(scl_m), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .frame_start(fs), .row_sync(rs), .data_valid(dv),
    .strobe(st), .sync_oe_n(soe), .bias_res_en(bias)
  );
  ssst_host ssst_host_i (.mclk(mclk), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ====================
  // Edge timestamps of the sync pins
  always @(posedge mclk) begin
    cyc++;
    if (fs && !fs_q) begin
      fs_gap = cyc - fs_t;
      st_gap = cyc - st_t;
      fs_t = cyc;
      dv_n = dv_acc;
      dv_acc = 0;
    end
    if (!fs && fs_q) fs_len = cyc - fs_t;
    if (rs && !rs_q) begin
      if (cyc - rs_t < rs_min) rs_min = cyc - rs_t;
      if (cyc - fs_t < ROW) rs_off = cyc - fs_t;
      rs_t = cyc;
    end
    if (!rs && rs_q) rs_len = cyc - rs_t;
    if (dv && !dv_q) dv_off = cyc - rs_t;
    if (st && !st_q) st_t = cyc;
    if (!st && st_q) st_len = cyc - st_t;
    dv_acc += int'(dv);
    fs_q = fs;
    rs_q = rs;
    dv_q = dv;
    st_q = st;
    if (cyc == 60000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ====================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    ssst_host_i.wr(a, d, ok);
    chk(16'(ok), 16'h0001);
  endtask : wr
  task automatic tally_and_finish;
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // ====================
  // Scenarios
  task automatic t_badaddr;
    logic k;
    ssst_host_i.start();
    ssst_host_i.put_byte(8'h68, k);
    ssst_host_i.stop();
    chk(16'(k), 16'h0000);
  endtask : t_badaddr
  task automatic t_pins;
    wr(`SSST_A_POWER, 8'h02);
    chk(16'(bias), 16'h0001);
    wr(`SSST_A_POWER, 8'h00);
    chk(16'(bias), 16'h0000);
    wr(`SSST_A_TRIST, 8'h00);
    chk(16'(soe), 16'h0001);
    wr(`SSST_A_TRIST, 8'h01);
    chk(16'(soe), 16'h0000);
  endtask : t_pins
  task automatic t_regs;
    logic [7:0] a [4] = '{8'h54, 8'h55, 8'h56, 8'h64};
    logic [7:0] v [4] = '{8'h03, 8'h02, 8'h21, 8'h0a};
    logic [7:0] d;
    logic       k;
    for (int i = 0; i < 4; i++) wr(a[i], v[i]);
    for (int i = 0; i < 4; i++) begin
      ssst_host_i.rd(a[i], d, k);
      chk({7'h00, k, d}, {8'h01, v[i]});
    end
  endtask : t_regs
  task automatic t_timing;
    logic [7:0] a [8] = '{8'h5f, 8'h60, 8'h69, 8'h68, 8'h6b, 8'h6a, 8'h6d, 8'h6c};
    logic [7:0] v [8] = '{8'h01, 8'h01, 8'h04, 8'h00, 8'h02, 8'h00, 8'h05, 8'h00};
    for (int i = 0; i < 8; i++) wr(a[i], v[i]);
    repeat (3 * FRM) @(negedge mclk);
    rs_min = 1000;
    repeat (2 * FRM) @(negedge mclk);
    chk(16'(rs_min), 16'(ROW));
    chk(16'(fs_gap), 16'(FRM));
    chk(16'(fs_len), 16'h0002);
    chk(16'(rs_len), 16'h0003);
    chk(16'(rs_off), 16'h0002);
    chk(16'(dv_n), 16'h000f);
    chk(16'(dv_off), 16'h0004);
  endtask : t_timing
  task automatic t_pol;
    wr(`SSST_A_POL, 8'h04);
    repeat (2 * FRM) @(negedge mclk);
    chk(16'(dv_n), 16'(FRM - 15));
    wr(`SSST_A_POL, 8'h00);
  endtask : t_pol
  task automatic t_strobe;
    wr(`SSST_A_TRIG, 8'h03);
    repeat (3 * FRM) @(negedge mclk);
    chk(16'(st_t), 16'h0000);
    wr(`SSST_A_TRIG, 8'h23);
    repeat (2 * FRM) @(negedge mclk);
    chk(16'(st_len), 16'(ROW));
    chk(16'(st_gap > 2 * ROW && st_gap <= 2 * ROW + 5), 16'h0001);
    // User start row three: strobe moves one row earlier than default
    wr(`SSST_A_STRB, 8'h03);
    wr(`SSST_A_TRIG, 8'h23);
    repeat (2 * FRM) @(negedge mclk);
    chk(16'(st_len), 16'(ROW));
    chk(16'(st_gap > 3 * ROW && st_gap <= 3 * ROW + 5), 16'h0001);
  endtask : t_strobe
  task automatic t_widen;
    int s0;
    s0 = st_t;
    wr(`SSST_A_TRIG, 8'h20);
    wr(`SSST_A_SHA, 8'h03);
    wr(`SSST_A_FSDLY, 8'h05);
    repeat (3 * FRM) @(negedge mclk);
    chk(16'(fs_gap), 16'(9 * (ROW + 2)));
    chk(16'(dv_off), 16'h0002);
    chk(16'(st_t), 16'(s0));
  endtask : t_widen
  initial begin
    resetn <= 1'b0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    t_badaddr();
    t_pins();
    t_regs();
    t_timing();
    t_pol();
    t_strobe();
    t_widen();
    tally_and_finish();
  end
endmodule : ssst_top_tb
`default_nettype wire
